// File: hw/mbps_pkg.sv
package mbps_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned OFF_HOLD_S = 5;
	localparam int unsigned PRESCALE_CYC = CLK_HZ / 1000;
	localparam int unsigned OFF_HOLD_MS = OFF_HOLD_S * 1000;
	localparam int unsigned DEBOUNCE_CYC = 2000;
	localparam int unsigned SETTLE_CYC = 2000;
	localparam logic [2:0] MBPS_STRAP_CARD = 3'h4;
	localparam logic [2:0] MBPS_STRAP_SERIAL = 3'h6;
	localparam int unsigned MBPS_BIT_SEL_HI = 2;
	localparam int unsigned MBPS_BIT_REC = 3;
	localparam int unsigned MBPS_BIT_FAULT = 4;
	localparam int unsigned MBPS_BIT_RST = 5;
	localparam int unsigned MBPS_BIT_BTN = 6;
	localparam int unsigned MBPS_BIT_SUSP = 7;
	localparam logic [7:0] MBPS_SYNC_RST = 8'h6F;

	typedef enum logic [1:0]
	{
		MBPS_BOOT_FLASH = 2'b00,
		MBPS_BOOT_CARD = 2'b01,
		MBPS_BOOT_SERIAL = 2'b10
	} mbps_boot_t;

	typedef enum logic [2:0]
	{
		MBPS_ST_FAULT = 3'b000,
		MBPS_ST_CARRIER = 3'b001,
		MBPS_ST_SETTLE = 3'b010,
		MBPS_ST_RUN = 3'b011,
		MBPS_ST_SUSPEND = 3'b100,
		MBPS_ST_OFF = 3'b101
	} mbps_state_t;

	typedef struct packed
	{
		logic carrier_supply_enable;
		logic carrier_standby_n;
		logic reset_out_n;
		logic usb_download;
		mbps_boot_t boot_source;
	} mbps_out_t;
endpackage : mbps_pkg

// File: hw/mbps_sequencer.sv
// Overview of operation
// - Decode three straps into flash, card, serial.
// - Low recovery input forces serial download.
// - Serial download takes image over primary USB.
// - Power circuits wait for fault release.
// - Then enable carrier supply and standby.
// - Finally release reset output and boot.
// - Carrier supply enable is active high.
// - Standby low signals suspend, core off.
// - External reset request low resets device.
// - Reset output held through sequencing.
// - Power button low requests wake.
// - Five-second button hold powers off.
module mbps_sequencer #(
	parameter int unsigned PRESCALE = mbps_pkg::PRESCALE_CYC,
	parameter int unsigned HOLD_TICKS = mbps_pkg::OFF_HOLD_MS,
	parameter int unsigned DEBOUNCE = mbps_pkg::DEBOUNCE_CYC,
	parameter int unsigned SETTLE = mbps_pkg::SETTLE_CYC
)
(
	// Clock and reset.
	input wire logic I_CLK_SYS,
	input wire logic I_RST_B,
	// Carrier pins.
	input wire logic [2:0] I_BOOT_SEL_N,
	input wire logic I_RECOVERY_FORCE_N,
	input wire logic I_INPUT_POWER_FAULT_N,
	input wire logic I_RESET_REQ_N,
	input wire logic I_POWER_BUTTON_N,
	input wire logic I_SUSPEND_REQ,
	// Module outputs.
	output logic O_POWER_CIRCUITS_EN,
	output logic O_CARRIER_SUPPLY_ENABLE,
	output logic O_CARRIER_STANDBY_N,
	output logic O_RESET_OUT_N,
	output logic O_USB_DOWNLOAD,
	output mbps_pkg::mbps_boot_t O_BOOT_SOURCE
);
	import mbps_pkg::*;

	typedef struct packed
	{
		logic [7:0] s1;
		logic [7:0] s2;
		mbps_state_t st;
		logic pwr_en;
		logic btn;
		logic [31:0] deb_cnt;
		logic [31:0] pre_cnt;
		logic [31:0] hold_cnt;
		logic [31:0] set_cnt;
		logic boot_latched;
		mbps_out_t out;
	} mbps_reg_t;

	mbps_reg_t r_q;
	mbps_reg_t r_d;

	// The fault stage starts low so that power stays off until a real sample of the pin
	// has passed both flip-flops; the button and reset request start at their idle level.
	localparam mbps_reg_t MBPS_REG_RST = '{
		s1: MBPS_SYNC_RST,
		s2: MBPS_SYNC_RST,
		st: MBPS_ST_FAULT,
		pwr_en: 1'b0,
		btn: 1'b1,
		deb_cnt: 32'h0,
		pre_cnt: 32'h0,
		hold_cnt: 32'h0,
		set_cnt: 32'h0,
		boot_latched: 1'b0,
		out: '{
			carrier_supply_enable: 1'b0,
			carrier_standby_n: 1'b0,
			reset_out_n: 1'b0,
			usb_download: 1'b0,
			boot_source: MBPS_BOOT_FLASH
		}
	};

	// Counters end one short of their limit because the count starts at zero.
	function automatic logic mbps_reached(input logic [31:0] cnt, input int unsigned limit);
		return (cnt >= limit - 1);
	endfunction : mbps_reached

	// Floating straps read high through pull-ups; ground reads low.
	// Codes that no rule names fall back to flash, the safe factory default.
	function automatic mbps_boot_t mbps_decode(input logic [2:0] sel, input logic rec_n);
		mbps_boot_t b;
		if (!rec_n)
		begin
			b = MBPS_BOOT_SERIAL;
		end
		else if (sel == MBPS_STRAP_SERIAL)
		begin
			b = MBPS_BOOT_SERIAL;
		end
		else if (sel == MBPS_STRAP_CARD)
		begin
			b = MBPS_BOOT_CARD;
		end
		else
		begin
			b = MBPS_BOOT_FLASH;
		end
		return b;
	endfunction : mbps_decode

	// Bit map of synchroniser stages: 0..2 straps, 3 recovery, 4 fault, 5 reset, 6 button, 7 suspend.
	// Only the second stage of each synchroniser is read by the logic below.
	logic [7:0] pins;
	logic [2:0] st_sel_n;
	logic st_rec_n;
	logic st_fault_n;
	logic st_rst_n;
	logic st_raw_btn_n;
	logic st_btn_n;
	logic st_susp;
	mbps_boot_t boot_now;

	assign pins = {I_SUSPEND_REQ, I_POWER_BUTTON_N, I_RESET_REQ_N, I_INPUT_POWER_FAULT_N,
		I_RECOVERY_FORCE_N, I_BOOT_SEL_N};
	assign st_sel_n = r_q.s2[MBPS_BIT_SEL_HI:0];
	assign st_rec_n = r_q.s2[MBPS_BIT_REC];
	assign st_fault_n = r_q.s2[MBPS_BIT_FAULT];
	assign st_rst_n = r_q.s2[MBPS_BIT_RST];
	assign st_raw_btn_n = r_q.s2[MBPS_BIT_BTN];
	assign st_btn_n = r_q.btn;
	assign st_susp = r_q.s2[MBPS_BIT_SUSP];

	// Decoded from synchronised pins only, so a strap moving mid-sample cannot split the latch.
	assign boot_now = mbps_decode(st_sel_n, st_rec_n);

	always_comb
	begin
		r_d = r_q;
		r_d.s1 = pins;
		r_d.s2 = r_q.s1;
		// Debounce: the filtered level moves only after the pin has disagreed long enough.
		// A pin that bounces restarts the wait, so only a steady level gets through.
		if (st_raw_btn_n == r_q.btn)
		begin
			r_d.deb_cnt = '0;
		end
		else if (mbps_reached(r_q.deb_cnt, DEBOUNCE))
		begin
			r_d.deb_cnt = '0;
			r_d.btn = st_raw_btn_n;
		end
		else
		begin
			r_d.deb_cnt = r_q.deb_cnt + 32'h1;
		end

		// Hold timing restarts whenever the button returns high.
		if (st_btn_n)
		begin
			r_d.pre_cnt = '0;
			r_d.hold_cnt = '0;
		end
		else if (mbps_reached(r_q.pre_cnt, PRESCALE))
		begin
			r_d.pre_cnt = '0;
			// The tick count saturates, so a very long press cannot wrap back to zero.
			if (r_q.hold_cnt < HOLD_TICKS)
			begin
				r_d.hold_cnt = r_q.hold_cnt + 32'h1;
			end
		end
		else
		begin
			r_d.pre_cnt = r_q.pre_cnt + 32'h1;
		end

		case (r_q.st)
			MBPS_ST_FAULT:
			begin
				r_d.pwr_en = 1'b0;
				r_d.out.carrier_supply_enable = 1'b0;
				r_d.out.carrier_standby_n = 1'b0;
				r_d.out.reset_out_n = 1'b0;
				r_d.boot_latched = 1'b0;
				// Power, carrier supply, standby and reset stay off while the input supply is reported bad.
				if (st_fault_n)
				begin
					r_d.pwr_en = 1'b1;
					r_d.st = MBPS_ST_CARRIER;
				end
			end
			MBPS_ST_CARRIER:
			begin
				// Both carrier outputs rise together one cycle after the power circuits.
				r_d.out.carrier_supply_enable = 1'b1;
				r_d.out.carrier_standby_n = 1'b1;
				r_d.set_cnt = '0;
				r_d.st = MBPS_ST_SETTLE;
			end
			MBPS_ST_SETTLE:
			begin
				// Reset stays low so carrier supplies can come up before boot.
				r_d.out.reset_out_n = 1'b0;
				if (mbps_reached(r_q.set_cnt, SETTLE))
				begin
					r_d.st = MBPS_ST_RUN;
					r_d.out.reset_out_n = 1'b1;
					// Straps are read once per sequence; later changes wait for a restart.
					if (!r_q.boot_latched)
					begin
						r_d.boot_latched = 1'b1;
						r_d.out.boot_source = boot_now;
						r_d.out.usb_download = (boot_now == MBPS_BOOT_SERIAL);
					end
				end
				else
				begin
					r_d.set_cnt = r_q.set_cnt + 32'h1;
				end
			end
			MBPS_ST_RUN:
			begin
				// Suspend is honoured only once booted; earlier it would strand the sequence.
				if (st_susp)
				begin
					r_d.out.carrier_standby_n = 1'b0;
					r_d.st = MBPS_ST_SUSPEND;
				end
			end
			MBPS_ST_SUSPEND:
			begin
				// Any filtered press wakes the module; the long-press timer runs alongside.
				if (!st_btn_n)
				begin
					r_d.out.carrier_standby_n = 1'b1;
					r_d.st = MBPS_ST_RUN;
				end
			end
			MBPS_ST_OFF:
			begin
				r_d.pwr_en = 1'b0;
				r_d.out.carrier_supply_enable = 1'b0;
				r_d.out.carrier_standby_n = 1'b0;
				r_d.out.reset_out_n = 1'b0;
				// Wake needs a fresh press, so the off hold itself cannot restart the module.
				if (!st_btn_n && r_q.hold_cnt == '0)
				begin
					r_d.st = MBPS_ST_FAULT;
				end
			end
			default:
			begin
				r_d.st = MBPS_ST_FAULT;
			end
		endcase

		// A long press wins over every state, suspend included, as the power-off is immediate.
		if (r_q.st != MBPS_ST_OFF && r_q.hold_cnt >= HOLD_TICKS)
		begin
			r_d.st = MBPS_ST_OFF;
			r_d.pwr_en = 1'b0;
			r_d.out.carrier_supply_enable = 1'b0;
			r_d.out.carrier_standby_n = 1'b0;
			r_d.out.reset_out_n = 1'b0;
		end

		// Reset request in any state, and loss of input power in any state but off, restart the whole sequence.
		if (!st_rst_n || (!st_fault_n && r_q.st != MBPS_ST_OFF))
		begin
			r_d.st = MBPS_ST_FAULT;
			r_d.out.reset_out_n = 1'b0;
			if (!st_fault_n)
			begin
				r_d.pwr_en = 1'b0;
				r_d.out.carrier_supply_enable = 1'b0;
				r_d.out.carrier_standby_n = 1'b0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			r_q <= MBPS_REG_RST;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	// Every output comes straight from a flip-flop, so the carrier never sees a glitch.
	assign O_POWER_CIRCUITS_EN = r_q.pwr_en;
	assign O_CARRIER_SUPPLY_ENABLE = r_q.out.carrier_supply_enable;
	assign O_CARRIER_STANDBY_N = r_q.out.carrier_standby_n;
	assign O_RESET_OUT_N = r_q.out.reset_out_n;
	assign O_USB_DOWNLOAD = r_q.out.usb_download;
	assign O_BOOT_SOURCE = r_q.out.boot_source;
endmodule : mbps_sequencer

// File: tb/mbps_properties.sv
module mbps_properties
	import mbps_pkg::*;
(
	// Clock, reset and pins.
	input logic I_CLK_SYS,
	input logic I_RST_B,
	input logic I_RECOVERY_FORCE_N,
	input logic I_INPUT_POWER_FAULT_N,
	input logic I_RESET_REQ_N,
	// Outputs watched.
	input logic O_POWER_CIRCUITS_EN,
	input logic O_CARRIER_SUPPLY_ENABLE,
	input logic O_CARRIER_STANDBY_N,
	input logic O_RESET_OUT_N,
	input logic O_USB_DOWNLOAD,
	input mbps_pkg::mbps_boot_t O_BOOT_SOURCE
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_B);
	sequence s_up;
		O_CARRIER_SUPPLY_ENABLE && O_CARRIER_STANDBY_N;
	endsequence
	property p_up;
		$rose(O_POWER_CIRCUITS_EN) |=> s_up;
	endproperty
	a_up: assert property (p_up) else $error("carrier power late");
	property p_fault;
		!I_INPUT_POWER_FAULT_N [*4] |-> !O_POWER_CIRCUITS_EN;
	endproperty
	a_fault: assert property (p_fault) else $error("power on during fault");
	property p_rst;
		O_RESET_OUT_N |-> O_CARRIER_SUPPLY_ENABLE && O_POWER_CIRCUITS_EN;
	endproperty
	a_rst: assert property (p_rst) else $error("reset released early");
	property p_hold;
		$rose(O_CARRIER_SUPPLY_ENABLE) && !O_RESET_OUT_N |-> !O_RESET_OUT_N [*4];
	endproperty
	a_hold: assert property (p_hold) else $error("settle too short");
	property p_req;
		!I_RESET_REQ_N [*4] |-> !O_RESET_OUT_N;
	endproperty
	a_req: assert property (p_req) else $error("reset request ignored");
	property p_usb;
		O_USB_DOWNLOAD == (O_BOOT_SOURCE == MBPS_BOOT_SERIAL);
	endproperty
	a_usb: assert property (p_usb) else $error("usb mode mismatch");
	property p_latch;
		O_RESET_OUT_N && $past(O_RESET_OUT_N) |-> $stable(O_BOOT_SOURCE);
	endproperty
	a_latch: assert property (p_latch) else $error("boot source moved");
	property p_rec;
		$rose(O_RESET_OUT_N) && !$past(I_RECOVERY_FORCE_N, 3) |-> O_BOOT_SOURCE == MBPS_BOOT_SERIAL;
	endproperty
	a_rec: assert property (p_rec) else $error("recovery not forced");
endmodule : mbps_properties

bind mbps_sequencer mbps_properties u_chk (.*);

// File: tb/mbps_carrier.sv
// Carrier supply: fault stays low for a while after each restart pulse.
module mbps_carrier
(
	input wire logic i_clk,
	input wire logic i_restart,
	output logic o_fault_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt_q = 0;
	always @(posedge i_clk)
		if (i_restart)
			cnt_q <= 0;
		else if (cnt_q < 6)
			cnt_q <= cnt_q + 1;
	assign o_fault_n = (cnt_q == 6);
endmodule : mbps_carrier

// File: tb/testbench.sv
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR %s exp %0h got %0h", nm, e, a); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import mbps_pkg::*;
	logic clk, rst_b, rec_n, req_n, btn_n, susp, restart, fault_n;
	logic pwr, sup, stby_n, rout_n, usb;
	logic [2:0] sel_n;
	mbps_boot_t boot;
	int n_errors = 0, n_compared = 0, cyc = 0;
	mbps_sequencer #(.PRESCALE(4), .HOLD_TICKS(5), .DEBOUNCE(3), .SETTLE(4)) u_dut (
		.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_BOOT_SEL_N(sel_n),
		.I_RECOVERY_FORCE_N(rec_n), .I_INPUT_POWER_FAULT_N(fault_n),
		.I_RESET_REQ_N(req_n), .I_POWER_BUTTON_N(btn_n), .I_SUSPEND_REQ(susp),
		.O_POWER_CIRCUITS_EN(pwr), .O_CARRIER_SUPPLY_ENABLE(sup),
		.O_CARRIER_STANDBY_N(stby_n), .O_RESET_OUT_N(rout_n),
		.O_USB_DOWNLOAD(usb), .O_BOOT_SOURCE(boot));
	mbps_carrier u_car (.i_clk(clk), .i_restart(restart), .o_fault_n(fault_n));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// The whole run needs well under a thousand cycles.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			stop_test();
		end
	end
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task wait_up;
		int i;
		for (i = 0; i < 60 && rout_n !== 1'b1; i++)
			wt(1);
	endtask : wait_up
	task boot_up(input logic [2:0] s, input logic r, input mbps_boot_t e);
		sel_n <= s;
		rec_n <= r;
		restart <= 1'b1;
		wt(1);
		restart <= 1'b0;
		wt(4);
		`CHK("held", 1'b0, rout_n)
		`CHK("pwr", 1'b0, pwr)
		wait_up();
		`CHK("boot", e, boot)
		`CHK("usb", e == MBPS_BOOT_SERIAL, usb)
		`CHK("stby", 1'b1, stby_n)
	endtask : boot_up
	task t_req;
		req_n <= 1'b0;
		wt(4);
		`CHK("req", 1'b0, rout_n)
		req_n <= 1'b1;
		wait_up();
		`CHK("reboot", 1'b1, rout_n)
	endtask : t_req
	task t_susp;
		susp <= 1'b1;
		wt(5);
		`CHK("susp", 1'b0, stby_n)
		susp <= 1'b0;
		btn_n <= 1'b0;
		wt(8);
		btn_n <= 1'b1;
		wt(12);
		`CHK("wake", 1'b1, stby_n)
	endtask : t_susp
	task t_btn;
		btn_n <= 1'b0;
		wt(16);
		btn_n <= 1'b1;
		wt(8);
		btn_n <= 1'b0;
		wt(16);
		`CHK("restart", 1'b1, sup)
		wt(20);
		`CHK("off", 3'h0, {sup, stby_n, rout_n})
		btn_n <= 1'b1;
		wt(8);
		btn_n <= 1'b0;
		wt(8);
		btn_n <= 1'b1;
		wait_up();
		`CHK("on", 1'b1, rout_n)
	endtask : t_btn
	task stop_test;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	initial
	begin
		rst_b = 1'b0;
		{rec_n, req_n, btn_n, susp, restart} = 5'h1C;
		sel_n = 3'h1;
		wt(2);
		rst_b <= 1'b1;
		boot_up(3'h1, 1'b1, MBPS_BOOT_FLASH);
		boot_up(3'h4, 1'b1, MBPS_BOOT_CARD);
		boot_up(3'h6, 1'b1, MBPS_BOOT_SERIAL);
		boot_up(3'h4, 1'b0, MBPS_BOOT_SERIAL);
		boot_up(3'h7, 1'b1, MBPS_BOOT_FLASH);
		t_req();
		t_susp();
		t_btn();
		stop_test();
	end
endmodule : testbench
